// file: src/alu_pkg.sv
// shared constants, opcodes and register map of the accumulator execution unit
package alu_pkg;

	// ==========================================================
	// clocking and timing
	localparam int CLK_MHZ        = 50;
	localparam int TICK_NS        = 1000;                        // watchdog tick period in ns
	localparam int TICK_CYCLES    = (TICK_NS * CLK_MHZ) / 1000;  // cycles per watchdog tick
	localparam int WDOG_TICKS_DEF = 2000;                        // ticks before expiry, plain default

	// ==========================================================
	// apb register byte addresses
	localparam logic [11:0] ADDR_INSTR   = 12'h000;
	localparam logic [11:0] ADDR_STATUS  = 12'h004;
	localparam logic [11:0] ADDR_PC      = 12'h008;
	localparam logic [11:0] ADDR_ACCUM   = 12'h00c;
	localparam logic [11:0] ADDR_WDOG    = 12'h010;
	localparam logic [11:0] ADDR_FILE_LO = 12'h040;
	localparam logic [11:0] ADDR_FILE_HI = 12'h07c;

	// ==========================================================
	// instruction word layout
	localparam int INS_OP_LSB   = 0;   // 5-bit opcode
	localparam int INS_DEST_BIT = 5;   // 0: accumulator, 1: data register
	localparam int INS_BIT_LSB  = 6;   // 3-bit bit position
	localparam int INS_REG_LSB  = 12;  // 4-bit data register index
	localparam int INS_IMM_LSB  = 16;  // 8-bit immediate or target address

	// ==========================================================
	// status word layout
	localparam int ST_BUSY = 0;
	localparam int ST_C    = 1;
	localparam int ST_HC   = 2;
	localparam int ST_Z    = 3;
	localparam int ST_SR   = 4;
	localparam int ST_WX   = 5;
	localparam int ST_SE   = 6;

	// ==========================================================
	// reset values
	localparam logic [7:0] ACC_RST   = 8'h00;
	localparam logic [7:0] PC_RST    = 8'h00;
	localparam logic       WFLAG_RST = 1'b1;

	// ==========================================================
	// opcodes, unlisted codes behave as no-operation
	typedef enum logic [4:0] {
		OP_NOP  = 5'h00, OP_ADD  = 5'h01, OP_ADDC = 5'h02, OP_ADDI = 5'h03,
		OP_AND  = 5'h04, OP_ANDI = 5'h05, OP_OR   = 5'h06, OP_ORI  = 5'h07,
		OP_CLR  = 5'h08, OP_BIT_ZERO = 5'h09, OP_KICK = 5'h0a, OP_COM  = 5'h0b,
		OP_DEC  = 5'h0c, OP_INC  = 5'h0d, OP_LDA  = 5'h0e, OP_STR  = 5'h0f,
		OP_LDI  = 5'h10, OP_CALL = 5'h11, OP_JUMP = 5'h12, OP_RET  = 5'h13,
		OP_RETV = 5'h14, OP_IRET = 5'h15, OP_RLC  = 5'h16, OP_RL   = 5'h17,
		OP_RRC  = 5'h18, OP_RR   = 5'h19
	} alu_op_e;

	// execution sequencer states
	typedef enum logic [1:0] {
		S_IDLE   = 2'b00,
		S_RUN    = 2'b01,
		S_SECOND = 2'b10
	} alu_state_e;

endpackage

// file: src/alu_exec_unit.sv
// accumulator execution unit with apb register access
//
// Contract
// - register plus accumulator, one cycle, to accumulator or register, four flags.
// - register plus accumulator plus carry, one cycle, either destination, four flags.
// - immediate plus accumulator into accumulator, one cycle, four flags.
// - register and accumulator, one cycle, either destination, zero flag only.
// - immediate and accumulator into accumulator, one cycle, zero flag only.
// - call takes two cycles, pushes return point, jumps, flags untouched.
// - clear accumulator or register in one cycle, zero flag updated.
// - clear one selected register bit in one cycle, flags untouched.
// - watchdog kick restarts counter in one cycle, updates expiry and sleep flags.
// - invert register into either destination in one cycle, zero flag.
// - decrement register into either destination in one cycle, zero flag only.
// - increment register into either destination in one cycle, zero flag only.
// - register moved to accumulator in one cycle, zero flag from value.
// - accumulator stored to register in one cycle, flags untouched.
// - immediate loaded into accumulator in one cycle, flags untouched.
// - or with register (chosen destination) or immediate (accumulator only), one cycle, zero only.
// - returns take two cycles, no flags; value return loads accumulator.
// - rotate left through carry: old carry to bit 0, bit 7 to carry.
// - rotate left without carry, bit 7 to bit 0, flags untouched.
// - rotate right through carry: old carry to bit 7, bit 0 to carry.
// - rotate right without carry, bit 0 to bit 7, flags untouched.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
module alu_exec_unit
	import alu_pkg::*;
#(
	parameter int WDOG_TICKS = WDOG_TICKS_DEF
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	// ==========================================================
	// state
	alu_state_e  state_reg, state_next;
	logic [31:0] instr_reg, instr_next;
	logic [7:0]  working_accumulator_reg, working_accumulator_next;
	logic        carry_flag_reg, carry_flag_next;
	logic        half_carry_flag_reg, half_carry_flag_next;
	logic        zero_flag_reg, zero_flag_next;
	logic        signed_range_flag_reg, signed_range_flag_next;
	logic [7:0]  pc_reg, pc_next;
	logic [1:0]  sp_reg, sp_next;
	logic [7:0]  stack_reg [4];
	logic [7:0]  stack_next [4];
	logic [7:0]  file_reg [16];
	logic [7:0]  file_next [16];
	logic [31:0] prdata_reg, prdata_next;

	// decoded fields and datapath
	alu_op_e     op;
	logic        dest_reg_sel;
	logic [2:0]  bit_pos;
	logic [3:0]  reg_idx;
	logic [7:0]  imm;
	logic [7:0]  opnd;
	logic [7:0]  add_y;
	logic        add_cin;
	logic [8:0]  sum;
	logic [4:0]  half_sum;
	logic        sum_ovf;
	logic [7:0]  result;
	logic        wr_acc;
	logic        wr_reg;
	logic        upd_z;
	logic        kick;
	logic        busy;
	logic        apb_access;
	logic        apb_wr;
	logic        addr_file;
	logic        addr_ok;

	// ==========================================================
	// decode of the latched instruction word
	assign op           = alu_op_e'(instr_reg[INS_OP_LSB +: 5]);
	assign dest_reg_sel = instr_reg[INS_DEST_BIT];
	assign bit_pos      = instr_reg[INS_BIT_LSB +: 3];
	assign reg_idx      = instr_reg[INS_REG_LSB +: 4];
	assign imm          = instr_reg[INS_IMM_LSB +: 8];
	assign opnd         = file_reg[reg_idx];
	assign busy         = (state_reg != S_IDLE);

	// shared adder; carry in only for the carry-chained add
	assign add_y    = (op == OP_ADDI) ? imm : opnd;
	assign add_cin  = (op == OP_ADDC) ? carry_flag_reg : 1'b0;
	assign sum      = {1'b0, working_accumulator_reg} + {1'b0, add_y} + {8'h00, add_cin};
	assign half_sum = {1'b0, working_accumulator_reg[3:0]} + {1'b0, add_y[3:0]}
	                  + {4'h0, add_cin};
	assign sum_ovf  = (working_accumulator_reg[7] == add_y[7])
	                  && (sum[7] != working_accumulator_reg[7]);

	// ==========================================================
	// apb decode; writes stall while an instruction runs so that
	// software never races the datapath on the same storage
	assign apb_access = psel & penable;
	assign addr_file  = (paddr >= ADDR_FILE_LO) && (paddr <= ADDR_FILE_HI)
	                    && (paddr[1:0] == 2'b00);
	assign addr_ok    = addr_file || (paddr == ADDR_INSTR) || (paddr == ADDR_STATUS)
	                    || (paddr == ADDR_PC) || (paddr == ADDR_ACCUM)
	                    || (paddr == ADDR_WDOG);
	assign pready     = ~(pwrite & busy);
	assign pslverr    = apb_access & pready & ~addr_ok;
	assign apb_wr     = apb_access & pwrite & pready & addr_ok;
	assign prdata     = prdata_reg;

	// ==========================================================
	// watchdog: tick divider, counter and the two power flags
	logic [5:0]  tick_cnt_reg, tick_cnt_next;
	logic [15:0] wdog_cnt_reg, wdog_cnt_next;
	logic        watchdog_expiry_flag_reg, watchdog_expiry_flag_next;
	logic        sleep_entry_flag_reg, sleep_entry_flag_next;
	logic        tick;
	logic        expire;

	assign tick   = (tick_cnt_reg == 6'(TICK_CYCLES - 1));
	assign expire = tick && (wdog_cnt_reg == 16'(WDOG_TICKS - 1));

	// flags read 1 while healthy; an expiry in the kick cycle still wins
	always_comb begin
		tick_cnt_next             = tick ? 6'h00 : tick_cnt_reg + 6'h01;
		wdog_cnt_next             = wdog_cnt_reg;
		watchdog_expiry_flag_next = watchdog_expiry_flag_reg;
		sleep_entry_flag_next     = sleep_entry_flag_reg;
		if (tick) begin
			wdog_cnt_next = wdog_cnt_reg + 16'h0001;
		end
		if (kick) begin
			wdog_cnt_next             = 16'h0000;
			watchdog_expiry_flag_next = 1'b1;
			sleep_entry_flag_next     = 1'b1;
		end
		if (expire) begin
			wdog_cnt_next             = 16'h0000;
			watchdog_expiry_flag_next = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt_reg             <= 6'h00;
			wdog_cnt_reg             <= 16'h0000;
			watchdog_expiry_flag_reg <= WFLAG_RST;
			sleep_entry_flag_reg     <= WFLAG_RST;
		end else begin
			tick_cnt_reg             <= tick_cnt_next;
			wdog_cnt_reg             <= wdog_cnt_next;
			watchdog_expiry_flag_reg <= watchdog_expiry_flag_next;
			sleep_entry_flag_reg     <= sleep_entry_flag_next;
		end
	end

	// ==========================================================
	// execution sequencer, datapath writeback and apb writes
	always_comb begin
		state_next               = state_reg;
		instr_next               = instr_reg;
		working_accumulator_next = working_accumulator_reg;
		carry_flag_next          = carry_flag_reg;
		half_carry_flag_next     = half_carry_flag_reg;
		zero_flag_next           = zero_flag_reg;
		signed_range_flag_next   = signed_range_flag_reg;
		pc_next                  = pc_reg;
		sp_next                  = sp_reg;
		stack_next               = stack_reg;
		file_next                = file_reg;
		result                   = 8'h00;
		wr_acc                   = 1'b0;
		wr_reg                   = 1'b0;
		upd_z                    = 1'b0;
		kick                     = 1'b0;
		unique case (state_reg)
			S_IDLE: begin
				if (apb_wr && paddr == ADDR_INSTR) begin
					instr_next = pwdata;
					state_next = S_RUN;
				end
				if (apb_wr && paddr == ADDR_ACCUM) begin
					working_accumulator_next = pwdata[7:0];
				end
				if (apb_wr && addr_file) begin
					file_next[paddr[5:2]] = pwdata[7:0];
				end
			end
			S_RUN: begin
				state_next = S_IDLE;
				pc_next    = pc_reg + 8'h01;
				case (op)
					OP_ADD, OP_ADDC, OP_ADDI: begin
						result                 = sum[7:0];
						wr_acc                 = (op == OP_ADDI) || !dest_reg_sel;
						wr_reg                 = (op != OP_ADDI) && dest_reg_sel;
						upd_z                  = 1'b1;
						carry_flag_next        = sum[8];
						half_carry_flag_next   = half_sum[4];
						signed_range_flag_next = sum_ovf;
					end
					OP_AND, OP_ANDI: begin
						result = working_accumulator_reg
						         & ((op == OP_ANDI) ? imm : opnd);
						wr_acc = (op == OP_ANDI) || !dest_reg_sel;
						wr_reg = (op == OP_AND) && dest_reg_sel;
						upd_z  = 1'b1;
					end
					OP_OR, OP_ORI: begin
						result = working_accumulator_reg
						         | ((op == OP_ORI) ? imm : opnd);
						wr_acc = (op == OP_ORI) || !dest_reg_sel;
						wr_reg = (op == OP_OR) && dest_reg_sel;
						upd_z  = 1'b1;
					end
					OP_CLR: begin
						result = 8'h00;
						wr_acc = !dest_reg_sel;
						wr_reg = dest_reg_sel;
						upd_z  = 1'b1;
					end
					OP_BIT_ZERO: begin
						result = opnd & ~(8'h01 << bit_pos);
						wr_reg = 1'b1;
					end
					OP_KICK: begin
						kick = 1'b1;
					end
					OP_COM, OP_DEC, OP_INC: begin
						if (op == OP_COM) begin
							result = ~opnd;
						end else if (op == OP_DEC) begin
							result = opnd - 8'h01;
						end else begin
							result = opnd + 8'h01;
						end
						wr_acc = !dest_reg_sel;
						wr_reg = dest_reg_sel;
						upd_z  = 1'b1;
					end
					OP_LDA: begin
						result = opnd;
						wr_acc = 1'b1;
						upd_z  = 1'b1;
					end
					OP_STR: begin
						result = working_accumulator_reg;
						wr_reg = 1'b1;
					end
					OP_LDI: begin
						result = imm;
						wr_acc = 1'b1;
					end
					OP_RLC, OP_RRC: begin
						if (op == OP_RLC) begin
							result          = {opnd[6:0], carry_flag_reg};
							carry_flag_next = opnd[7];
						end else begin
							result          = {carry_flag_reg, opnd[7:1]};
							carry_flag_next = opnd[0];
						end
						wr_acc = !dest_reg_sel;
						wr_reg = dest_reg_sel;
					end
					OP_RL, OP_RR: begin
						result = (op == OP_RL) ? {opnd[6:0], opnd[7]}
						                       : {opnd[0], opnd[7:1]};
						wr_acc = !dest_reg_sel;
						wr_reg = dest_reg_sel;
					end
					OP_CALL, OP_JUMP, OP_RET, OP_IRET: begin
						state_next = S_SECOND;
						pc_next    = pc_reg;
					end
					OP_RETV: begin
						result     = imm;
						wr_acc     = 1'b1;
						state_next = S_SECOND;
						pc_next    = pc_reg;
					end
					default: begin
						// no-operation and unused codes only advance the counter
						result = 8'h00;
					end
				endcase
				if (wr_acc) begin
					working_accumulator_next = result;
				end
				if (wr_reg) begin
					file_next[reg_idx] = result;
				end
				if (upd_z) begin
					zero_flag_next = (result == 8'h00);
				end
			end
			S_SECOND: begin
				// the return stack wraps silently: a fifth call overwrites the oldest entry
				state_next = S_IDLE;
				if (op == OP_CALL) begin
					stack_next[sp_reg] = pc_reg + 8'h01;
					sp_next            = sp_reg + 2'h1;
					pc_next            = imm;
				end else if (op == OP_JUMP) begin
					pc_next = imm;
				end else begin
					sp_next = sp_reg - 2'h1;
					pc_next = stack_reg[sp_reg - 2'h1];
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg               <= S_IDLE;
			instr_reg               <= 32'h0000_0000;
			working_accumulator_reg <= ACC_RST;
			carry_flag_reg          <= 1'b0;
			half_carry_flag_reg     <= 1'b0;
			zero_flag_reg           <= 1'b0;
			signed_range_flag_reg   <= 1'b0;
			pc_reg                  <= PC_RST;
			sp_reg                  <= 2'h0;
			for (int i = 0; i < 4; i++) begin
				stack_reg[i] <= 8'h00;
			end
			for (int i = 0; i < 16; i++) begin
				file_reg[i] <= 8'h00;
			end
		end else begin
			state_reg               <= state_next;
			instr_reg               <= instr_next;
			working_accumulator_reg <= working_accumulator_next;
			carry_flag_reg          <= carry_flag_next;
			half_carry_flag_reg     <= half_carry_flag_next;
			zero_flag_reg           <= zero_flag_next;
			signed_range_flag_reg   <= signed_range_flag_next;
			pc_reg                  <= pc_next;
			sp_reg                  <= sp_next;
			stack_reg               <= stack_next;
			file_reg                <= file_next;
		end
	end

	// ==========================================================
	// read data captured in the setup phase, held through access
	always_comb begin
		prdata_next = prdata_reg;
		if (psel && !penable && !pwrite) begin
			prdata_next = 32'h0000_0000;
			if (addr_file) begin
				prdata_next = {24'h000000, file_reg[paddr[5:2]]};
			end else if (paddr == ADDR_INSTR) begin
				prdata_next = instr_reg;
			end else if (paddr == ADDR_STATUS) begin
				prdata_next[ST_BUSY] = busy;
				prdata_next[ST_C]    = carry_flag_reg;
				prdata_next[ST_HC]   = half_carry_flag_reg;
				prdata_next[ST_Z]    = zero_flag_reg;
				prdata_next[ST_SR]   = signed_range_flag_reg;
				prdata_next[ST_WX]   = watchdog_expiry_flag_reg;
				prdata_next[ST_SE]   = sleep_entry_flag_reg;
			end else if (paddr == ADDR_PC) begin
				prdata_next = {22'h000000, sp_reg, pc_reg};
			end else if (paddr == ADDR_ACCUM) begin
				prdata_next = {24'h000000, working_accumulator_reg};
			end else if (paddr == ADDR_WDOG) begin
				prdata_next = {16'h0000, wdog_cnt_reg};
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	logic run_single;
	assign run_single = (state_reg == S_RUN) && (state_next == S_IDLE);

	chk_add_result: assert property ((state_reg == S_RUN) && op == OP_ADD && !dest_reg_sel
		|=> working_accumulator_reg == $past(sum[7:0]) && carry_flag_reg == $past(sum[8]))
		else $error("add result or carry wrong");
	chk_addc_carry: assert property ((state_reg == S_RUN) && op == OP_ADDC && dest_reg_sel
		|=> file_reg[$past(reg_idx)] == $past(sum[7:0]) && half_carry_flag_reg == $past(half_sum[4]))
		else $error("carry add wrong");
	chk_addi_ovf: assert property ((state_reg == S_RUN) && op == OP_ADDI
		|=> signed_range_flag_reg == $past(sum_ovf) && state_reg == S_IDLE)
		else $error("immediate add wrong");
	chk_logic_flags: assert property ((state_reg == S_RUN) && (op == OP_AND || op == OP_OR)
		|=> $stable(carry_flag_reg) && $stable(half_carry_flag_reg) && $stable(signed_range_flag_reg))
		else $error("logic op touched arithmetic flags");
	chk_call_flow: assert property ((state_reg == S_RUN) && op == OP_CALL
		|=> state_reg == S_SECOND ##1 state_reg == S_IDLE && pc_reg == $past(imm, 2)
		&& stack_reg[$past(sp_reg, 2)] == $past(pc_reg, 2) + 8'h01)
		else $error("call sequence wrong");
	chk_bit_clear: assert property ((state_reg == S_RUN) && op == OP_BIT_ZERO
		|=> file_reg[$past(reg_idx)][$past(bit_pos)] == 1'b0 && $stable(zero_flag_reg))
		else $error("bit clear wrong");
	chk_kick_flags: assert property (kick && !expire
		|=> watchdog_expiry_flag_reg && sleep_entry_flag_reg && wdog_cnt_reg == 16'h0000)
		else $error("watchdog kick wrong");
	chk_rot_carry: assert property ((state_reg == S_RUN) && op == OP_RRC && !dest_reg_sel
		|=> working_accumulator_reg == {$past(carry_flag_reg), $past(opnd[7:1])}
		&& carry_flag_reg == $past(opnd[0]))
		else $error("rotate through carry wrong");
	chk_zero_flag: assert property (run_single && upd_z
		|=> zero_flag_reg == ($past(result) == 8'h00))
		else $error("zero flag wrong");
	chk_nop_quiet: assert property ((state_reg == S_RUN) && op == OP_NOP
		|=> $stable(working_accumulator_reg) && $stable(carry_flag_reg) && $stable(zero_flag_reg)
		&& pc_reg == $past(pc_reg) + 8'h01)
		else $error("no-operation changed state");

	cov_call_run: cover property ((state_reg == S_RUN) && op == OP_CALL ##2 state_reg == S_IDLE);
	cov_ret_value: cover property ((state_reg == S_RUN) && op == OP_RETV);
	cov_add_ovf: cover property ((state_reg == S_RUN) && op == OP_ADD && sum_ovf);
	cov_stall: cover property (psel && penable && !pready);

endmodule

// file: test/alu_exec_unit_tb.sv
// self-checking testbench of the accumulator execution unit, model compared after every op
`timescale 1ns/1ns
module alu_exec_unit_tb
	import alu_pkg::*;
;

	// ==========================================================
	// design signals and model state
	logic        clock;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic [31:0] ins;
	logic        er;
	logic [7:0]  m_acc;
	logic [7:0]  m_pc;
	logic [7:0]  res;
	logic [7:0]  opd;
	logic [7:0]  m_rf [16];
	logic [7:0]  m_stk [4];
	logic        mc;
	logic        mh;
	logic        mz;
	logic        mv;
	int          bad_count;
	int          check_count;
	int          seed;
	int          s;
	int          sp;
	int          i;

	// short watchdog count keeps the expiry scenario within a few hundred cycles
	alu_exec_unit #(.WDOG_TICKS(3)) dut (
		.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
	);

	// ==========================================================
	// verdict, comparison and apb master
	task tally_and_finish;
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				bad_count++;
				tally_and_finish();
			end
			@(posedge clock);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// ==========================================================
	// one instruction: model update, then busy span, flags, accumulator, pc, register
	task run(input logic [31:0] iw);
		logic [4:0] op;
		logic [3:0] ri;
		logic [7:0] r;
		logic [7:0] im;
		logic       dst;
		logic       wa;
		logic       wr;
		op = iw[4:0]; dst = iw[5]; ri = iw[15:12]; im = iw[23:16]; r = m_rf[ri];
		wa = 1'b0; wr = 1'b0; res = 8'h00;
		m_pc = m_pc + 8'h01;
		apb(1'b1, ADDR_INSTR, iw);
		case (op)
			1, 2, 3: begin
				opd = (op == 3) ? im : r;
				s = m_acc + opd + ((op == 2) ? mc : 1'b0);
				mh = (m_acc[3:0] + opd[3:0] + ((op == 2) ? mc : 1'b0)) > 15;
				mc = s > 255;
				res = s[7:0];
				mv = (m_acc[7] == opd[7]) && (res[7] != m_acc[7]);
				mz = res == 8'h00; wa = (op == 3) | !dst; wr = !wa;
			end
			4, 5, 6, 7: begin
				opd = op[0] ? im : r;
				res = op[1] ? (m_acc | opd) : (m_acc & opd);
				mz = res == 8'h00; wa = op[0] | !dst; wr = !wa;
			end
			8: begin mz = 1'b1; wa = !dst; wr = dst; end
			9: begin res = r; res[iw[8:6]] = 1'b0; wr = 1'b1; end
			11, 12, 13, 14: begin
				res = (op == 11) ? ~r : (op == 12) ? r - 8'h01 : (op == 13) ? r + 8'h01 : r;
				mz = res == 8'h00; wa = (op == 14) | !dst; wr = !wa;
			end
			15: begin res = m_acc; wr = 1'b1; end
			16: begin res = im; wa = 1'b1; end
			17: begin m_stk[sp] = m_pc; sp = (sp + 1) % 4; m_pc = im; end
			18: m_pc = im;
			19, 20, 21: begin
				sp = (sp + 3) % 4; m_pc = m_stk[sp];
				res = im; wa = op == 20;
			end
			22, 23, 24, 25: begin
				res = (op == 22) ? {r[6:0], mc} : (op == 23) ? {r[6:0], r[7]} :
					(op == 24) ? {mc, r[7:1]} : {r[0], r[7:1]};
				if (op == 22) mc = r[7];
				if (op == 24) mc = r[0];
				wa = !dst; wr = dst;
			end
			default: ;
		endcase
		if (wa) m_acc = res;
		if (wr) m_rf[ri] = res;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[0], op >= 5'h11 && op <= 5'h15);
		repeat (2) if (rd[0] !== 1'b0) apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h1f, {27'h0, mv, mz, mh, mc, 1'b0});
		apb(1'b0, ADDR_ACCUM, 32'h0);
		chk(rd, {24'h0, m_acc});
		apb(1'b0, ADDR_PC, 32'h0);
		chk(rd[7:0], m_pc);
		apb(1'b0, ADDR_FILE_LO + {6'h0, ri, 2'b00}, 32'h0);
		chk(rd, {24'h0, m_rf[ri]});
	endtask

	// ==========================================================
	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		#(20 * 60000);
		bad_count++;
		tally_and_finish();
	end

	// ==========================================================
	// main sequence
	initial begin
		sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; seed = 52673; bad_count = 0; check_count = 0;
		m_acc = ACC_RST; m_pc = PC_RST; sp = 0; mc = 0; mh = 0; mz = 0; mv = 0;
		for (i = 0; i < 16; i++) m_rf[i] = 8'h00;
		// the return stack powers up cleared, so a return before any call pops zero
		for (i = 0; i < 4; i++) m_stk[i] = 8'h00;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h60);
		apb(1'b0, ADDR_PC, 32'h0);
		chk(rd, 32'h0);
		// unmapped places answer with an error and read zero
		apb(1'b0, 12'h020, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, 12'h030, 32'h55);
		chk(er, 1'b1);
		// random register file and accumulator contents
		for (i = 0; i < 16; i++) begin
			m_rf[i] = 8'($random(seed));
			apb(1'b1, ADDR_FILE_LO + 12'(i * 4), {24'h0, m_rf[i]});
		end
		m_acc = 8'($random(seed));
		apb(1'b1, ADDR_ACCUM, {24'h0, m_acc});
		// every opcode once, including unlisted ones, then random mixes
		for (i = 0; i < 400; i++) begin
			ins = $random(seed);
			if (i < 32) ins[4:0] = i[4:0];
			ins[31:24] = 8'h00;
			ins[11:9] = 3'b000;
			run(ins);
		end
		// a write set up during the second cycle of a two-cycle jump reaches access after the jump is done, then lands
		m_pc = 8'h5a;
		m_acc = 8'hc3;
		apb(1'b1, ADDR_INSTR, 32'h005a0012);
		apb(1'b1, ADDR_ACCUM, {24'h0, m_acc});
		apb(1'b0, ADDR_ACCUM, 32'h0);
		chk(rd, {24'h0, m_acc});
		apb(1'b0, ADDR_PC, 32'h0);
		chk(rd[7:0], m_pc);
		// watchdog kick, expiry with no kick, then kick again
		run(32'h0000000a);
		chk(rd[7:0], m_rf[0]);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[6:5], 2'b11);
		repeat (200) @(posedge clock);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[6:5], 2'b10);
		run(32'h0000000a);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[6:5], 2'b11);
		tally_and_finish();
	end
endmodule
